/* File: shared/enc_cond_pkg.sv */
// Shared constants and types of the encoder input conditioning block
package enc_cond_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int NREG = 13;
    localparam logic [15:0] OFS_CONTROL = 16'hBA00;
    localparam logic [15:0] OFS_PIN_IO = 16'hBA10;
    localparam logic [15:0] OFS_STATE = 16'hBA20;
    localparam logic [15:0] OFS_ANGLE_CNT = 16'hBA30;
    localparam logic [15:0] OFS_ANGLE_HOLD = 16'hBA40;
    localparam logic [15:0] OFS_SPEED_CNT = 16'hBA50;
    localparam logic [15:0] OFS_SPEED_HOLD = 16'hBA60;
    localparam logic [15:0] OFS_INTERVAL_TMR = 16'hBA70;
    localparam logic [15:0] OFS_INTERVAL_HOLD = 16'hBA80;
    localparam logic [15:0] OFS_MARKER_CNT = 16'hBA90;
    localparam logic [15:0] OFS_MARKER_HOLD = 16'hBAA0;
    localparam logic [15:0] OFS_HIGH_CMP = 16'hBAB0;
    localparam logic [15:0] OFS_LOW_CMP = 16'hBAC0;
    localparam logic [15:0] REG_OFS [NREG] = '{
        OFS_CONTROL, OFS_PIN_IO, OFS_STATE, OFS_ANGLE_CNT, OFS_ANGLE_HOLD,
        OFS_SPEED_CNT, OFS_SPEED_HOLD, OFS_INTERVAL_TMR, OFS_INTERVAL_HOLD,
        OFS_MARKER_CNT, OFS_MARKER_HOLD, OFS_HIGH_CMP, OFS_LOW_CMP};
    localparam int IX_CONTROL = 0;
    localparam int IX_PIN_IO = 1;
    localparam int IX_STATE = 2;
    localparam int IX_ANGLE_CNT = 3;
    localparam int IX_ANGLE_HOLD = 4;
    localparam int IX_MARKER_CNT = 9;
    localparam int IX_MARKER_HOLD = 10;
    localparam int IX_HIGH_CMP = 11;
    localparam int IX_LOW_CMP = 12;

    // Alias selector in address bits 3:2
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_CLEAR = 2'h1;
    localparam logic [1:0] OP_SET = 2'h2;
    localparam logic [1:0] OP_INVERT = 2'h3;

    // Writable masks and reset value
    localparam logic [31:0] WMASK_CONTROL = 32'h0000FFFF;
    localparam logic [31:0] WMASK_PIN_IO = 32'h0001FFF0;
    localparam logic [31:0] WMASK_STATE = 32'h00000002;
    localparam logic [31:0] WMASK_FULL = 32'hFFFFFFFF;
    localparam logic [31:0] RESET_VALUE = 32'h00000000;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_ENCODER_ENABLE = 15;
    localparam int BIT_REF_EDGE_CAPTURE_ENABLE = 16;
    localparam int BIT_CAPTURE_FUNCTION_ENABLE = 15;
    localparam int BIT_INPUT_FILTER_ENABLE = 14;
    localparam int POS_FILTER_CLOCK_DIVIDER = 11;
    localparam int POS_COMPARE_OUTPUT_FUNCTION = 9;
    localparam int BIT_PHASE_SWAP = 8;
    localparam int BIT_REF_INPUT_INVERT = 7;
    localparam int BIT_MARKER_INPUT_INVERT = 6;
    localparam int BIT_PHASE_B_INVERT = 5;
    localparam int BIT_PHASE_A_INVERT = 4;
    localparam int BIT_STATE_COMPARE = 0;
    localparam int BIT_STATE_CAPTURED = 1;

    // Compare output function codes
    localparam logic [1:0] CMP_OFF = 2'h0;
    localparam logic [1:0] CMP_HIGH = 2'h1;
    localparam logic [1:0] CMP_LOW = 2'h2;
    localparam logic [1:0] CMP_EITHER = 2'h3;

    // Filter: divider width and samples needed to accept a level
    localparam int DIV_CODE_W = 3;
    localparam int FILTER_SAMPLES = 3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Encoder pins travel together
    typedef struct packed {
        logic home;
        logic marker;
        logic phaseB;
        logic phaseA;
    } enc_pins_s;

endpackage

/* File: hdl/filter_tick_gen.sv */
// Sample strobe for the input filter, divided by a power of two
module filter_tick_gen #(
    parameter int DIV_W = 3
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [DIV_W-1:0] divCode,
    output logic tick
);
    localparam int CNT_W = (1 << DIV_W) - 1;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] limit;

    // Code n gives one strobe every 2**n clocks
    assign limit = CNT_W'((1 << divCode) - 1);
    assign tick = (count_r >= limit);

    always_ff @(posedge ref_clk) begin
        if (rst || tick) begin
            count_r <= '0;
        end else begin
            count_r <= count_r + 1'b1;
        end
    end
endmodule

/* File: hdl/glitch_filter.sv */
// Level filter: accepts a new level after equal consecutive samples
module glitch_filter #(
    parameter int SAMPLES = 3
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic din,
    output logic dout
);
    logic [SAMPLES-1:0] hist_r;
    logic allHigh;
    logic allLow;

    assign allHigh = &hist_r;
    assign allLow = ~|hist_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hist_r <= '0;
            dout <= 1'b0;
        end else if (tick) begin
            hist_r <= {hist_r[SAMPLES-2:0], din};
            if (allHigh) begin
                dout <= 1'b1;
            end else if (allLow) begin
                dout <= 1'b0;
            end
        end
    end
endmodule

/* File: hdl/encoder_input_conditioning.sv */
// Encoder input conditioning, capture, compare pin and register file
// What this block does
// - Ref edge capture enable makes a rising home edge latch the count.
// - Capture function enable also starts capture on a rising home edge.
// - Filter enable routes all four inputs through the filter, else bypass.
// - The 3-bit divider field slows filter sampling by 2**code, to 1:128.
// - Compare codes 10 and 01 test count <= low and count >= high.
// - Code 11 drives the pin on either test; code 00 keeps it low.
// - Phase swap exchanges A and B ahead of quadrature decoding.
// - Bits 7, 6 and 5 invert home, marker and phase B inputs.
// - Pin control low byte: four polarity bits, four live input bits.
// - Pin control bits 31-17 read as zero.
// - Each register has clear, set and invert aliases at +4, +8, +C.
// - Reset clears control, counters, timers and holds to zero.
//
// Design decision made here: register access over AXI4-Lite.
module encoder_input_conditioning (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire enc_cond_pkg::enc_pins_s encPins,
    output enc_cond_pkg::enc_pins_s condPins,
    output logic count_compare_pin
);
    import enc_cond_pkg::*;

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    function automatic int regIndex(input logic [15:0] addr);
        regIndex = -1;
        for (int i = 0; i < NREG; i++) begin
            if (addr[15:4] == REG_OFS[i][15:4]) begin
                regIndex = i;
            end
        end
    endfunction

    function automatic logic [31:0] writeMask(input int idx);
        writeMask = WMASK_FULL;
        if (idx == IX_CONTROL) begin
            writeMask = WMASK_CONTROL;
        end else if (idx == IX_PIN_IO) begin
            writeMask = WMASK_PIN_IO;
        end else if (idx == IX_STATE) begin
            writeMask = WMASK_STATE;
        end
    endfunction

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [31:0] regs_r [NREG];
    logic [31:0] regs_nxt [NREG];

    logic [31:0] ctrlReg;
    logic [31:0] ioReg;
    assign ctrlReg = regs_r[IX_CONTROL];
    assign ioReg = regs_r[IX_PIN_IO];

    logic encoderEnable;
    logic refCaptureEn;
    logic captureFuncEn;
    logic filterEn;
    logic [DIV_CODE_W-1:0] divCode;
    logic [1:0] cmpFunc;
    logic phaseSwap;
    enc_pins_s invertMask;
    assign encoderEnable = ctrlReg[BIT_ENCODER_ENABLE];
    assign refCaptureEn = ioReg[BIT_REF_EDGE_CAPTURE_ENABLE];
    assign captureFuncEn = ioReg[BIT_CAPTURE_FUNCTION_ENABLE];
    assign filterEn = ioReg[BIT_INPUT_FILTER_ENABLE];
    assign divCode =
        ioReg[POS_FILTER_CLOCK_DIVIDER +: DIV_CODE_W];
    assign cmpFunc = ioReg[POS_COMPARE_OUTPUT_FUNCTION +: 2];
    assign phaseSwap = ioReg[BIT_PHASE_SWAP];
    assign invertMask = ioReg[BIT_PHASE_A_INVERT +: 4];

    // ----------------------------------------------------------------
    // Pin conditioning
    // ----------------------------------------------------------------
    // Pins are asynchronous; two flops before any logic reads them
    enc_pins_s syncA_r;
    enc_pins_s syncB_r;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            syncA_r <= '0;
            syncB_r <= '0;
        end else begin
            syncA_r <= encPins;
            syncB_r <= syncA_r;
        end
    end

    logic filterTick;
    filter_tick_gen #(
        .DIV_W(DIV_CODE_W)
    ) u_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .divCode(divCode),
        .tick(filterTick)
    );

    enc_pins_s filtered;
    generate
        for (genvar g = 0; g < 4; g++) begin : g_filter
            glitch_filter #(
                .SAMPLES(FILTER_SAMPLES)
            ) u_filt (
                .ref_clk(ref_clk),
                .rst(rst),
                .tick(filterTick),
                .din(syncB_r[g]),
                .dout(filtered[g])
            );
        end
    endgenerate

    enc_pins_s selected;
    enc_pins_s polarized;
    enc_pins_s condNxt;
    assign selected = filterEn ? filtered : syncB_r;
    assign polarized = selected ^ invertMask;
    assign condNxt = '{
        home: polarized.home,
        marker: polarized.marker,
        phaseB: phaseSwap ? polarized.phaseA : polarized.phaseB,
        phaseA: phaseSwap ? polarized.phaseB : polarized.phaseA
    };

    // Registered so every consumer sees the same conditioned sample
    enc_pins_s prev_r;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            condPins <= '0;
            prev_r <= '0;
        end else begin
            condPins <= condNxt;
            prev_r <= condPins;
        end
    end

    // ----------------------------------------------------------------
    // Quadrature count, capture and compare
    // ----------------------------------------------------------------
    logic stepValid;
    logic stepUp;
    logic homeRise;
    logic markerRise;
    logic doCapture;
    assign stepValid = encoderEnable &&
        ((condPins.phaseA ^ prev_r.phaseA) ^
         (condPins.phaseB ^ prev_r.phaseB));
    assign stepUp = condPins.phaseA ^ prev_r.phaseB;
    assign homeRise = condPins.home && !prev_r.home;
    assign markerRise = encoderEnable && condPins.marker && !prev_r.marker;
    assign doCapture = homeRise && (refCaptureEn || captureFuncEn);

    logic signed [31:0] angleCount;
    logic atOrBelowLow;
    logic atOrAboveHigh;
    logic cmpNxt;
    assign angleCount = regs_r[IX_ANGLE_CNT];
    assign atOrBelowLow = angleCount <= $signed(regs_r[IX_LOW_CMP]);
    assign atOrAboveHigh = angleCount >= $signed(regs_r[IX_HIGH_CMP]);
    assign cmpNxt = (cmpFunc == CMP_EITHER) ? (atOrBelowLow || atOrAboveHigh)
                  : (cmpFunc == CMP_LOW) ? atOrBelowLow
                  : (cmpFunc == CMP_HIGH) ? atOrAboveHigh
                  : 1'b0;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_compare_pin <= 1'b0;
        end else begin
            count_compare_pin <= cmpNxt;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    logic awHeld_r;
    logic wHeld_r;
    logic [15:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic doWrite;
    int wrIdx;
    logic [1:0] wrOp;
    logic [31:0] wrBits;
    assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
    assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
    assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
    assign wrIdx = regIndex(awAddr_r);
    assign wrOp = awAddr_r[3:2];
    assign wrBits = wData_r & {{8{wStrb_r[3]}}, {8{wStrb_r[2]}},
                               {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= '0;
            wData_r <= '0;
            wStrb_r <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wrIdx < 0) ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Register next state
    // ----------------------------------------------------------------
    // Hardware updates first, software write last: a counter written
    // by software takes the written value, but the capture flag is
    // set again below so an event in the clearing cycle survives.
    always_comb begin
        logic [31:0] m;
        logic [31:0] cur;
        m = '0;
        cur = '0;
        for (int i = 0; i < NREG; i++) begin
            regs_nxt[i] = regs_r[i];
        end
        if (stepValid) begin
            regs_nxt[IX_ANGLE_CNT] = stepUp ? regs_r[IX_ANGLE_CNT] + 32'h1
                                            : regs_r[IX_ANGLE_CNT] - 32'h1;
        end
        if (markerRise) begin
            regs_nxt[IX_MARKER_CNT] = regs_r[IX_MARKER_CNT] + 32'h1;
        end
        if (doCapture) begin
            regs_nxt[IX_ANGLE_HOLD] = regs_r[IX_ANGLE_CNT];
            regs_nxt[IX_MARKER_HOLD] = regs_r[IX_MARKER_CNT];
        end
        if (doWrite && wrIdx >= 0) begin
            m = wrBits & writeMask(wrIdx);
            cur = regs_nxt[wrIdx];
            unique case (wrOp)
                OP_WRITE: cur = (cur & ~writeMask(wrIdx)) | m;
                OP_CLEAR: cur = cur & ~m;
                OP_SET: cur = cur | m;
                OP_INVERT: cur = cur ^ m;
            endcase
            regs_nxt[wrIdx] = cur;
        end
        if (doCapture) begin
            regs_nxt[IX_STATE][BIT_STATE_CAPTURED] = 1'b1;
        end
    end

    generate
        for (genvar r = 0; r < NREG; r++) begin : g_reg
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    regs_r[r] <= RESET_VALUE;
                end else begin
                    regs_r[r] <= regs_nxt[r];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    int rdIdx;
    logic [31:0] rdValue;
    assign rdIdx = regIndex(s_axi_araddr);
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rdValue = '0;
        if (rdIdx >= 0) begin
            rdValue = regs_r[rdIdx] & writeMask(rdIdx);
        end
        if (rdIdx == IX_PIN_IO) begin
            // Live conditioned levels; upper bits stay zero
            rdValue[3:0] = condPins;
        end
        if (rdIdx == IX_STATE) begin
            rdValue[BIT_STATE_COMPARE] = count_compare_pin;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdValue;
            s_axi_rresp <= (rdIdx < 0) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

/* File: verification/encoder_input_conditioning_sva.sv */
// Port assertions of the encoder input conditioning block
module encoder_input_conditioning_sva (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire enc_cond_pkg::enc_pins_s condPins,
    input wire logic count_compare_pin
);
    import enc_cond_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // Address of the read in flight, so read data is judged per register
    logic [15:0] rdAddr_r;
    logic [15:0] rdAddr_nxt;
    assign rdAddr_nxt = s_axi_arvalid && s_axi_arready ? s_axi_araddr
                                                       : rdAddr_r;
    always_ff @(posedge ref_clk) begin
        rdAddr_r <= rst ? 16'h0 : rdAddr_nxt;
    end
    sequence wrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rdTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence rdFresh(logic [15:0] a);
        $rose(s_axi_rvalid) && rdAddr_r == a;
    endsequence
    reset_idle_a:
        assert property ($fell(rst) |-> !s_axi_bvalid && !s_axi_rvalid
            && condPins == 4'h0 && !count_compare_pin)
        else $error("outputs not idle after reset");
    write_answer_a:
        assert property (wrTaken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response not two edges after request");
    read_answer_a:
        assert property (rdTaken |=> s_axi_rvalid)
        else $error("read data not one edge after request");
    resp_hold_a:
        assert property (s_axi_bvalid && !s_axi_bready
            |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before accepted");
    read_hold_a:
        assert property (s_axi_rvalid && !s_axi_rready
            |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before accepted");
    upper_zero_a:
        assert property (s_axi_rvalid && rdAddr_r == OFS_PIN_IO
            |-> s_axi_rdata[31:17] == 15'h0)
        else $error("pin control upper bits not zero");
    live_pins_a:
        assert property (rdFresh(OFS_PIN_IO)
            |-> s_axi_rdata[3:0] == $past(condPins))
        else $error("pin control low bits differ from live pins");
    cmp_mirror_a:
        assert property (rdFresh(OFS_STATE)
            |-> s_axi_rdata[0] == $past(count_compare_pin))
        else $error("state bit differs from compare pin");
endmodule
bind encoder_input_conditioning encoder_input_conditioning_sva
    encoder_input_conditioning_sva_i (.ref_clk, .rst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .condPins, .count_compare_pin);

/* File: verification/enc_model.sv */
// Incremental encoder model that drives the four encoder pins
module enc_model (
    input wire logic ref_clk,
    output enc_cond_pkg::enc_pins_s encPins
);
    import enc_cond_pkg::*;
    initial encPins = 4'h0;
    task automatic put(input logic [3:0] p);
        @(posedge ref_clk);
        encPins <= p;
    endtask
    task automatic pulse(input logic [3:0] m, input int width);
        @(posedge ref_clk);
        encPins <= encPins ^ m;
        repeat (width) @(posedge ref_clk);
        encPins <= encPins ^ m;
    endtask
    // One phase moves per step, A leads B counting up; gap sets shaft speed
    task automatic step(input logic up, input int gap);
        logic same;
        repeat (gap + 1) @(posedge ref_clk);
        same = encPins.phaseA == encPins.phaseB;
        if (same == up)
            encPins.phaseA <= !encPins.phaseA;
        else
            encPins.phaseB <= !encPins.phaseB;
    endtask
endmodule

/* File: verification/tb_encoder_input_conditioning.sv */
// Self-checking bench of the encoder input conditioning block
module tb_encoder_input_conditioning;
    timeunit 1ns;
    timeprecision 1ps;
    import enc_cond_pkg::*;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, count_compare_pin;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rdat;
    enc_pins_s encPins, condPins;
    int err_total = 0, check_count = 0, cycles = 0;
    always #4 ref_clk = ~ref_clk;
    encoder_input_conditioning encoder_input_conditioning_i (.ref_clk, .rst,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .encPins, .condPins, .count_compare_pin);
    enc_model enc_model_i (.ref_clk, .encPins);
    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Each channel is judged at the rising edge at which it is taken
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
        rd(a);
        chk(rdat, exp);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_zero;
        for (int i = 0; i < NREG; i++)
            rdc(REG_OFS[i], 32'h0);
        $display("reset values done");
    endtask
    task automatic t_alias;
        wr(OFS_CONTROL, 32'h000000F0);
        wr(OFS_CONTROL + 16'h8, 32'h0000000F);
        rdc(OFS_CONTROL, 32'h000000FF);
        wr(OFS_CONTROL + 16'h4, 32'h000000F0);
        rdc(OFS_CONTROL, 32'h0000000F);
        wr(OFS_CONTROL + 16'hC, 32'h00000101);
        rdc(OFS_CONTROL, 32'h0000010E);
        wr(OFS_PIN_IO, 32'hFFFF81F0);
        waitc(4);
        rdc(OFS_PIN_IO, 32'h000181FF);
        wr(16'hBAD0, 32'hFFFFFFFF);
        chk(32'(resp), 32'(RESP_SLVERR));
        rdc(16'hBAD0, 32'h0);
        chk(32'(resp), 32'(RESP_SLVERR));
        wr(OFS_CONTROL, 32'h0);
        $display("alias access done");
    endtask
    task automatic t_pins;
        logic [3:0] e;
        enc_model_i.put(4'hA);
        for (int i = 0; i < 32; i++) begin
            wr(OFS_PIN_IO, 32'(i) << 4);
            e = 4'hA ^ 4'(i);
            if (i[4])
                e = {e[3:2], e[0], e[1]};
            waitc(4);
            @(negedge ref_clk);
            chk(32'(condPins), 32'(e));
        end
        $display("polarity and swap done");
    endtask
    // A pulse two ticks wide must vanish; a steady level passes in time
    task automatic t_filter;
        int p;
        enc_model_i.put(4'h0);
        for (int c = 0; c < 8; c++) begin
            p = 1 << c;
            wr(OFS_PIN_IO, 32'h4000 | 32'(c << 11));
            waitc(4 * p + 8);
            enc_model_i.pulse(4'h1, 2 * p);
            waitc(4 * p);
            @(negedge ref_clk);
            chk(32'(condPins.phaseA), 32'h0);
            enc_model_i.put(4'h1);
            waitc(2 * p);
            @(negedge ref_clk);
            chk(32'(condPins.phaseA), 32'h0);
            waitc(2 * p + 8);
            @(negedge ref_clk);
            chk(32'(condPins.phaseA), 32'h1);
            enc_model_i.put(4'h0);
        end
        $display("input filter done");
    endtask
    task automatic t_capture;
        wr(OFS_PIN_IO, 32'h0);
        wr(OFS_CONTROL, 32'h8000);
        for (int k = 0; k < 6; k++)
            enc_model_i.step(1'h1, k);
        waitc(6);
        rdc(OFS_ANGLE_CNT, 32'h6);
        for (int m = 0; m < 3; m++) begin
            wr(OFS_PIN_IO, 32'(m) << 15);
            wr(OFS_ANGLE_HOLD, 32'h0);
            wr(OFS_STATE + 16'h4, 32'h2);
            enc_model_i.pulse(4'h8, 4);
            waitc(6);
            rdc(OFS_ANGLE_HOLD, m > 0 ? 32'h6 : 32'h0);
            rdc(OFS_STATE, m > 0 ? 32'h2 : 32'h0);
        end
        $display("home capture done");
    endtask
    // Counts sit on and next to both thresholds
    task automatic t_compare;
        int vals[4] = '{3, 4, 9, 10};
        logic e;
        wr(OFS_HIGH_CMP, 32'h0000000A);
        wr(OFS_LOW_CMP, 32'h00000003);
        for (int j = 0; j < 4; j++) begin
            wr(OFS_ANGLE_CNT, 32'(vals[j]));
            for (int c = 0; c < 4; c++) begin
                wr(OFS_PIN_IO, 32'(c) << 9);
                e = (c[0] && vals[j] >= 10) || (c[1] && vals[j] <= 3);
                waitc(3);
                @(negedge ref_clk);
                chk(32'(count_compare_pin), 32'(e));
            end
        end
        $display("compare pin done");
    endtask
    initial begin
        waitc(2);
        rst <= 1'h0;
        t_zero();
        t_alias();
        t_pins();
        t_filter();
        t_capture();
        t_compare();
        enc_model_i.put(4'h0);
        rst <= 1'h1;
        waitc(2);
        rst <= 1'h0;
        t_zero();
        close_out();
    end
endmodule
